// *** logic/slc_alert_flags.sv ***
// twelve-slot level and ceiling alert flags behind an AXI4-Lite slave
//
// Design decision made here: the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
module slc_alert_flags
   import slc_pkg::*;
(
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // sequencer update events
   input wire slc_update_t upd,
   // axi4-lite write address and data
   input wire logic awvalid,
   output logic awready,
   input wire logic [11:0] awaddr,
   input wire logic [2:0] awprot,
   input wire logic wvalid,
   output logic wready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   // axi4-lite write response
   output logic bvalid,
   input wire logic bready,
   output logic [1:0] bresp,
   // axi4-lite read
   input wire logic arvalid,
   output logic arready,
   input wire logic [11:0] araddr,
   input wire logic [2:0] arprot,
   output logic rvalid,
   input wire logic rready,
   output logic [31:0] rdata,
   output logic [1:0] rresp
);

   // register map, byte address = four times the register index:
   //   0x08 level-zero alert flags, one bit per slot, A in bit 0 to L in bit 11
   //   0x0c level-one alert flags, same slot order
   //   0x10 channel-one ceiling flags, same slot order
   // bits 31 to 12 of every flag register read zero and ignore writes
   // any other address reads zero and answers with an error; writes there are dropped
   // flags are write-one-to-clear: software reads, handles, then writes back the bits it saw,
   // which cannot lose an event that arrives between the read and the write
   // the block holds one write and one read at a time; readies drop from acceptance
   // until the response is taken, so a master that keeps its requests up simply waits
   // update events are taken as they come on this clock; the sequencer must pulse
   // update for exactly one cycle per data register update, slots 12 to 15 are ignored
   // limitation: only byte lanes 0 and 1 reach flag bits, a write with neither strobe
   // set completes normally and clears nothing

   slc_state_t s_q;
   slc_state_t s_d;

   // register index of an aligned byte address below 0x40, or all ones for any other address
   function automatic logic [3:0] reg_index(input logic [11:0] addr);
      if (addr[1:0] != 2'h0 || addr[11:6] != 6'h00) begin
         return 4'hf;
      end
      return addr[5:2];
   endfunction

   // true for the three flag registers; every other index answers with an error
   function automatic logic mapped(input logic [3:0] idx);
      return idx == SLC_IDX_LEVEL_ZERO || idx == SLC_IDX_LEVEL_ONE ||
             idx == SLC_IDX_CEILING;
   endfunction

   // response code for an access to the given index
   // reads and writes share it so both sides of the bus agree on what is mapped
   function automatic logic [1:0] resp_of(input logic [3:0] idx);
      logic [1:0] code;
      code = SLC_RESP_SLVERR;
      if (mapped(idx)) begin
         code = SLC_RESP_OKAY;
      end
      return code;
   endfunction

   // one-hot slot select for an update event
   // slots beyond L select nothing, so a stray slot number cannot touch a reserved bit
   function automatic logic [11:0] slot_select(input slc_update_t u);
      logic [11:0] sel;
      sel = 12'h000;
      if (u.update && u.slot < 4'(SLC_NUM_SLOTS)) begin
         sel[u.slot] = 1'b1;
      end
      return sel;
   endfunction

   // clear mask from a write; only byte lanes 0 and 1 reach flag bits, and
   // the reserved top nibble of lane 1 is dropped here
   function automatic logic [11:0] clear_mask(input logic [31:0] data, input logic [3:0] strb);
      logic [11:0] mask;
      mask = 12'h000;
      if (strb[0]) begin
         mask[7:0] = data[7:0];
      end
      if (strb[1]) begin
         mask[11:8] = data[11:8];
      end
      return mask;
   endfunction

   // next value of one flag register: the write clears first, then the update sets,
   // so an event landing in the same cycle as its clear is never lost
   function automatic logic [11:0] next_flags(input logic [11:0] cur, input logic [11:0] clr,
      input logic [11:0] set);
      return (cur & ~clr) | set;
   endfunction

   // flag register widened to the bus; bits 31 to 12 are reserved and read zero
   function automatic logic [31:0] bus_word(input logic [11:0] flags);
      return {20'h00000, flags};
   endfunction

   // read data for an index, taken from the flags as they stand at acceptance
   function automatic logic [31:0] read_word(input logic [3:0] idx, input slc_flags_t f);
      logic [31:0] word;
      word = 32'h00000000;
      case (idx)
         SLC_IDX_LEVEL_ZERO: begin
            word = bus_word(f.level_zero);
         end
         SLC_IDX_LEVEL_ONE: begin
            word = bus_word(f.level_one);
         end
         SLC_IDX_CEILING: begin
            word = bus_word(f.ceiling);
         end
         default: begin
            word = 32'h00000000;
         end
      endcase
      return word;
   endfunction

   // update side
   logic [11:0] hit;
   logic [11:0] set_lz;
   logic [11:0] set_lo;
   logic [11:0] set_ce;
   // write side
   logic aw_take;
   logic w_take;
   logic b_done;
   logic do_write;
   logic [3:0] widx;
   logic [11:0] wclr;
   logic [11:0] clr_lz;
   logic [11:0] clr_lo;
   logic [11:0] clr_ce;
   // read side
   logic ar_take;
   logic r_done;
   logic [3:0] ridx;

   // the whole next state is worked out here from the registered state and the inputs, and only state registers drive the outputs,
   // so no output of the block depends combinationally on a bus input
   always_comb begin
      s_d = s_q;

      // update events: each criterion result feeds its own register
      hit = slot_select(upd);
      set_lz = 12'h000;
      set_lo = 12'h000;
      set_ce = 12'h000;
      if (upd.level_zero_met) begin
         set_lz = hit;
      end
      if (upd.level_one_met) begin
         set_lo = hit;
      end
      if (upd.ceiling_exceeded) begin
         set_ce = hit;
      end

      // write side: address and data caught in either order and held until both are in
      aw_take = awvalid && s_q.bus.awready;
      w_take = wvalid && s_q.bus.wready;
      if (aw_take) begin
         s_d.bus.aw_held = 1'b1;
         s_d.bus.awaddr = awaddr;
         s_d.bus.awready = 1'b0;
      end
      if (w_take) begin
         s_d.bus.w_held = 1'b1;
         s_d.bus.wdata = wdata;
         s_d.bus.wstrb = wstrb;
         s_d.bus.wready = 1'b0;
      end

      // a write takes effect the cycle after both halves are held
      do_write = s_q.bus.aw_held && s_q.bus.w_held && !s_q.bus.bvalid;
      widx = reg_index(s_q.bus.awaddr);
      wclr = 12'h000;
      if (do_write) begin
         wclr = clear_mask(s_q.bus.wdata, s_q.bus.wstrb);
         s_d.bus.bvalid = 1'b1;
         s_d.bus.bresp = resp_of(widx);
         s_d.bus.aw_held = 1'b0;
         s_d.bus.w_held = 1'b0;
      end
      // readies return only after the response is taken: one write in flight at most
      b_done = s_q.bus.bvalid && bready;
      if (b_done) begin
         s_d.bus.bvalid = 1'b0;
         s_d.bus.awready = 1'b1;
         s_d.bus.wready = 1'b1;
      end

      // a write to an unmapped index clears nothing
      clr_lz = 12'h000;
      clr_lo = 12'h000;
      clr_ce = 12'h000;
      if (do_write && widx == SLC_IDX_LEVEL_ZERO) begin
         clr_lz = wclr;
      end
      if (do_write && widx == SLC_IDX_LEVEL_ONE) begin
         clr_lo = wclr;
      end
      if (do_write && widx == SLC_IDX_CEILING) begin
         clr_ce = wclr;
      end

      // set wins over a clear landing in the same cycle
      s_d.flags.level_zero = next_flags(s_q.flags.level_zero, clr_lz, set_lz);
      s_d.flags.level_one = next_flags(s_q.flags.level_one, clr_lo, set_lo);
      s_d.flags.ceiling = next_flags(s_q.flags.ceiling, clr_ce, set_ce);

      // read side: one outstanding read, answered the cycle after acceptance;
      // the data is a snapshot, later updates show on the next read
      ridx = reg_index(araddr);
      ar_take = arvalid && s_q.bus.arready;
      if (ar_take) begin
         s_d.bus.arready = 1'b0;
         s_d.bus.rvalid = 1'b1;
         s_d.bus.rresp = resp_of(ridx);
         s_d.bus.rdata = read_word(ridx, s_q.flags);
      end
      r_done = s_q.bus.rvalid && rready;
      if (r_done) begin
         s_d.bus.rvalid = 1'b0;
         s_d.bus.arready = 1'b1;
      end
   end

   // synchronous reset: every field gets a constant, the bus comes up idle and ready,
   // so the first request may arrive at the first edge after release
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_q <= '0;
         // flags clear on reset and stay clear until an update sets them
         s_q.flags.level_zero <= SLC_FLAGS_RESET;
         s_q.flags.level_one <= SLC_FLAGS_RESET;
         s_q.flags.ceiling <= SLC_FLAGS_RESET;
         // write channels idle and ready
         s_q.bus.aw_held <= 1'b0;
         s_q.bus.awaddr <= 12'h000;
         s_q.bus.w_held <= 1'b0;
         s_q.bus.wdata <= 32'h00000000;
         s_q.bus.wstrb <= 4'h0;
         s_q.bus.bvalid <= 1'b0;
         s_q.bus.bresp <= SLC_RESP_OKAY;
         s_q.bus.awready <= 1'b1;
         s_q.bus.wready <= 1'b1;
         // read channel idle and ready
         s_q.bus.rvalid <= 1'b0;
         s_q.bus.rresp <= SLC_RESP_OKAY;
         s_q.bus.rdata <= 32'h00000000;
         s_q.bus.arready <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end

   // every output comes straight from a state register
   // write channels
   assign awready = s_q.bus.awready;
   assign wready = s_q.bus.wready;
   assign bvalid = s_q.bus.bvalid;
   assign bresp = s_q.bus.bresp;
   // read channel
   assign arready = s_q.bus.arready;
   assign rvalid = s_q.bus.rvalid;
   assign rdata = s_q.bus.rdata;
   assign rresp = s_q.bus.rresp;

endmodule

// *** logic/slc_pkg.sv ***
// package for the slot level and ceiling alert flag block
package slc_pkg;
   // printed offsets are word indices; byte address is four times the index
   localparam logic [3:0] SLC_IDX_LEVEL_ZERO = 4'h2;
   localparam logic [3:0] SLC_IDX_LEVEL_ONE = 4'h3;
   localparam logic [3:0] SLC_IDX_CEILING = 4'h4;
   localparam int SLC_NUM_SLOTS = 12;
   localparam int SLC_REG_WIDTH = 16;
   localparam logic [11:0] SLC_FLAGS_RESET = 12'h000;
   localparam logic [1:0] SLC_RESP_OKAY = 2'h0;
   localparam logic [1:0] SLC_RESP_SLVERR = 2'h2;

   // one data-register update event from the sequencer
   typedef struct packed {
      logic update;
      logic [3:0] slot;
      logic level_zero_met;
      logic level_one_met;
      logic ceiling_exceeded;
   } slc_update_t;

   typedef struct packed {
      logic [11:0] level_zero;
      logic [11:0] level_one;
      logic [11:0] ceiling;
   } slc_flags_t;

   typedef struct packed {
      logic aw_held;
      logic [11:0] awaddr;
      logic w_held;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic awready;
      logic wready;
      logic arready;
   } slc_bus_t;

   typedef struct packed {
      slc_flags_t flags;
      slc_bus_t bus;
   } slc_state_t;
endpackage

// *** verification/slc_alert_flags_asserts.sv ***
// checker for the slot alert flag block
`timescale 1ns/1ns
module slc_alert_flags_asserts
   import slc_pkg::*;
(
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // watched signals
   input wire slc_update_t upd,
   input wire logic arvalid,
   input wire logic arready,
   input wire logic [11:0] araddr,
   input wire logic rvalid,
   input wire logic rready,
   input wire logic [31:0] rdata,
   input wire logic bvalid,
   input wire logic bready
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   sequence hit(s, m);
      upd.update && upd.slot == s && m;
   endsequence
   sequence rd_of(a);
      arvalid && arready && araddr == a;
   endsequence
   lz_slot_a_a: assert property (
      hit(0, upd.level_zero_met) ##[1:10] rd_of(12'h008) |=> rdata[0])
      else $error("slot a level zero flag missing");
   lo_slot_l_a: assert property (
      hit(11, upd.level_one_met) ##[1:10] rd_of(12'h00c) |=> rdata[11])
      else $error("slot l level one flag missing");
   ceil_slot_k_a: assert property (
      hit(10, upd.ceiling_exceeded) ##[1:10] rd_of(12'h010) |=> rdata[10])
      else $error("slot k ceiling flag missing");
   rd_answer_a: assert property (arvalid && arready |=> rvalid)
      else $error("read answer missing");
   rd_hold_a: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
      else $error("read data dropped early");
   rsv_zero_a: assert property (rvalid |-> rdata[31:12] == 20'h0)
      else $error("reserved bits not zero");
   b_hold_a: assert property (bvalid && !bready |=> bvalid)
      else $error("write response dropped early");
endmodule

// *** verification/slc_alert_flags_bench.sv ***
// self-checking bench for the slot alert flag block
`timescale 1ns/1ns
module slc_alert_flags_bench import slc_pkg::*; ;
   logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
   logic arvalid, arready, rvalid, rready;
   slc_update_t upd;
   logic [11:0] awaddr, araddr, want [3];
   logic [2:0] awprot, arprot;
   logic [31:0] wdata, rdata, d;
   logic [3:0] wstrb, idx [3];
   logic [1:0] bresp, rresp, resp;
   int bad_count, tests_run, cyc, j;
   slc_alert_flags slc_alert_flags_inst (.aclk, .aresetn, .upd, .awvalid, .awready, .awaddr,
      .awprot, .wvalid, .wready, .wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready,
      .araddr, .arprot, .rvalid, .rready, .rdata, .rresp);
   initial begin
      aclk = 1'b0;
      forever #10 aclk = ~aclk;
   end
   always @(posedge aclk) begin
      cyc++;
      if (cyc == 20000) begin
         bad_count++;
         report_and_stop();
      end
   end
   task automatic chk(input string n, input logic [31:0] s, e);
      tests_run++;
      if (s !== e) begin
         bad_count++;
         $display("unexpected %s expected %h seen %h", n, e, s);
      end
   endtask
   // the update pulse ends at the first edge of the next access, so a read can follow it
   task automatic wr(input logic [11:0] a, input logic [31:0] v, input logic [3:0] s);
      logic ta, tw;
      {ta, tw} = 2'b00;
      @(posedge aclk);
      upd <= '0;
      {awvalid, wvalid, awaddr, wdata, wstrb} <= {2'b11, a, v, s};
      while (!(ta && tw)) begin
         @(negedge aclk);
         {ta, tw} = {ta | awready, tw | wready};
         @(posedge aclk);
         if (ta) awvalid <= 1'b0;
         if (tw) wvalid <= 1'b0;
      end
      do @(negedge aclk); while (!bvalid);
      resp = bresp;
      @(posedge aclk) bready <= 1'b1;
      @(posedge aclk) bready <= 1'b0;
   endtask
   task automatic rd(input logic [11:0] a);
      @(posedge aclk);
      upd <= '0;
      {arvalid, araddr} <= {1'b1, a};
      do @(negedge aclk); while (!arready);
      @(posedge aclk) arvalid <= 1'b0;
      do @(negedge aclk); while (!rvalid);
      {d, resp} = {rdata, rresp};
      // late ready keeps the answer standing for a cycle
      @(posedge aclk) rready <= 1'b1;
      @(posedge aclk) rready <= 1'b0;
   endtask
   task report_and_stop;
      $display("checks %0d mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   initial begin
      {aresetn, upd, awvalid, awaddr, awprot, wvalid, wdata, wstrb} = '0;
      {bready, arvalid, araddr, arprot, rready} = '0;
      idx = '{SLC_IDX_LEVEL_ZERO, SLC_IDX_LEVEL_ONE, SLC_IDX_CEILING};
      want = '{default: SLC_FLAGS_RESET};
      d = $urandom(32'h774e);
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      for (int n = 0; n < 300; n++) begin
         if (n > 0) begin
            d = $urandom;
            // slots 12 to 15 must be ignored
            @(posedge aclk) upd <= {1'b1, d[6:0]};
            if (d[6:3] < 12) begin
               want[0][d[6:3]] |= d[2];
               want[1][d[6:3]] |= d[1];
               want[2][d[6:3]] |= d[0];
            end
         end
         for (int i = 0; i < 3; i++) begin
            j = (i + n) % 3;
            rd({6'h0, idx[j], 2'b00});
            chk("flags", d, {20'h0, want[j]});
            chk("rresp", {30'h0, resp}, {30'h0, SLC_RESP_OKAY});
         end
         j = $urandom % 3;
         d = $urandom;
         wr({6'h0, idx[j], 2'b00}, d, d[31:28]);
         want[j] &= ~{d[29] ? d[11:8] : 4'h0, d[28] ? d[7:0] : 8'h00};
         chk("bresp", {30'h0, resp}, {30'h0, SLC_RESP_OKAY});
      end
      // reset in mid-run must bring every flag back to zero
      @(posedge aclk) aresetn <= 1'b0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      want = '{default: SLC_FLAGS_RESET};
      for (int i = 0; i < 3; i++) begin
         rd({6'h0, idx[i], 2'b00});
         chk("flags after reset", d, {20'h0, want[i]});
      end
      wr(12'h014, 32'hffffffff, 4'hf);
      chk("bresp", {30'h0, resp}, {30'h0, SLC_RESP_SLVERR});
      rd(12'h000);
      chk("rresp", {30'h0, resp}, {30'h0, SLC_RESP_SLVERR});
      chk("unmapped rdata", d, 32'h0);
      report_and_stop();
   end
endmodule
bind slc_alert_flags slc_alert_flags_asserts slc_alert_flags_asserts_inst (.aclk, .aresetn,
   .upd, .arvalid, .arready, .araddr, .rvalid, .rready, .rdata, .bvalid, .bready);
